// file: core/jal_pkg.sv
// Constants, encodings and field layouts shared by the link alignment and framing core.
// Assumes one octet or one 64-bit block per clock on a 40 MHz core clock.
package jal_pkg;

  typedef enum logic {MODE_8B10B, MODE_64B66B} link_mode_e;

  // Core clock
  localparam int CLK_PERIOD_NS = 25;

  // 8b/10b alignment characters, carried as data byte plus control flag
  localparam logic [7:0] K28_7_CODE = 8'hFC;
  localparam logic [7:0] K28_3_CODE = 8'h7C;
  localparam logic [7:0] FRAME_MARK_OCTET = 8'hFC;
  localparam logic [7:0] MF_MARK_OCTET = 8'h7C;
  localparam logic [7:0] OCT_RESET = 8'h00;

  // 8b/10b scrambler 1 + x^14 + x^15
  localparam int SCR8_W = 15;
  localparam int SCR8_TAP_A = 14;
  localparam int SCR8_TAP_B = 15;
  localparam logic [14:0] SCR8_SEED = 15'h7FFF;

  // 64b/66b scrambler 1 + x^39 + x^58
  localparam int SCR66_W = 58;
  localparam int SCR66_TAP_A = 39;
  localparam int SCR66_TAP_B = 58;
  localparam logic [57:0] SCR66_SEED = 58'h3FF_FFFF_FFFF_FFFF;

  // Block layout
  localparam int OCTETS_PER_BLK = 8;
  localparam int BLK_DATA_W = 64;
  localparam int SH_W = 2;
  localparam int BLK_W = 66;
  localparam int MB_BLOCKS = 32;
  localparam int BLK_IDX_W = 5;
  localparam logic [4:0] BLK_IDX_LAST = 5'h1F;
  localparam int EMB_LEN = 1;
  localparam int LEMC_LINE_BITS = BLK_W * MB_BLOCKS * EMB_LEN;

  // Sync header stream layout
  localparam int SHS_W = 32;
  localparam int EOEMB_BIT = 22;
  localparam int CRC_W = 12;
  localparam int CRC_FIELD_END = 16;
  localparam int CRC_PILOT_STRIDE = 4;
  localparam logic [31:0] CRC_PILOT_MASK = 32'h80A8_8888;
  localparam int FEC_W = 26;
  localparam int FEC_FIELD_END = 27;
  localparam logic [31:0] FEC_PILOT_MASK = 32'h8000_0000;

  // Parity generators
  localparam logic [11:0] CRC_POLY = 12'h987;
  localparam logic [25:0] FEC_POLY = 26'h022_0211;

  // Frame and multiframe counters
  localparam int CNT_W = 8;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [4:0] BLK_ZERO = 5'h00;
  localparam logic [4:0] BLK_ONE = 5'h01;

endpackage

// file: core/link_core_if.sv
// Carrier between the framing core, its scrambler and its multiblock parity generator.
// Assumes all three sit on the same clock.
`timescale 1ns/1ps
interface link_core_if;
  logic oct_step;
  logic oct_scr_en;
  logic [7:0] oct_raw;
  logic [7:0] oct_scr;
  logic blk_step;
  logic [63:0] blk_raw;
  logic [63:0] blk_scr;
  logic par_step;
  logic par_first;
  logic par_last;
  logic par_fec;
  logic [25:0] par_word;

  modport core (
    output oct_step, oct_scr_en, oct_raw, blk_step, blk_raw,
    output par_step, par_first, par_last, par_fec,
    input oct_scr, blk_scr, par_word
  );
  modport scramble_enable (
    input oct_step, oct_scr_en, oct_raw, blk_step, blk_raw,
    output oct_scr, blk_scr
  );
  modport par (
    input par_step, par_first, par_last, par_fec, blk_scr,
    output par_word
  );
endinterface // link_core_if

// file: core/line_scrambler.sv
// Self-synchronous scramblers for octets (8b/10b) and 64-bit blocks (64b/66b).
// Assumes one step per clock at most; scrambled data appear in the same cycle.
`timescale 1ns/1ps
module line_scrambler (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Core side
  link_core_if.scramble_enable lc
);

  logic [14:0] st8;
  logic [14:0] next_st8;
  logic [57:0] st66;
  logic [57:0] next_st66;

  function automatic logic [22:0] scr8_step(input logic [14:0] st, input logic [7:0] d);
    logic [14:0] s;
    logic [7:0] o;
    logic b;
    s = st;
    o = '0;
    for (int i = 7; i >= 0; i--) begin
      b = d[i] ^ s[jal_pkg::SCR8_TAP_A-1] ^ s[jal_pkg::SCR8_TAP_B-1];
      o[i] = b;
      s = {s[13:0], b};
    end
    return {s, o};
  endfunction

  // Bit 0 leaves first, so it is scrambled first
  function automatic logic [121:0] scr66_step(input logic [57:0] st, input logic [63:0] d);
    logic [57:0] s;
    logic [63:0] o;
    logic b;
    s = st;
    o = '0;
    for (int i = 0; i < jal_pkg::BLK_DATA_W; i++) begin
      b = d[i] ^ s[jal_pkg::SCR66_TAP_A-1] ^ s[jal_pkg::SCR66_TAP_B-1];
      o[i] = b;
      s = {s[56:0], b};
    end
    return {s, o};
  endfunction

  always_comb begin
    logic [22:0] r8;
    logic [121:0] r66;
    r8 = scr8_step(st8, lc.oct_raw);
    r66 = scr66_step(st66, lc.blk_raw);
    next_st8 = st8;
    next_st66 = st66;
    lc.oct_scr = lc.oct_scr_en ? r8[7:0] : lc.oct_raw;
    lc.blk_scr = r66[63:0];
    if (lc.oct_step && lc.oct_scr_en) begin
      next_st8 = r8[22:8];
    end
    if (lc.blk_step) begin
      next_st66 = r66[121:64];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st8 <= jal_pkg::SCR8_SEED;
      st66 <= jal_pkg::SCR66_SEED;
    end else begin
      st8 <= next_st8;
      st66 <= next_st66;
    end
  end

endmodule // line_scrambler

// file: core/mb_parity.sv
// CRC-12 and FEC-26 parity over the scrambled 2048 bits of each multiblock.
// Assumes the core marks the first and last block; the held word serves the next multiblock.
`timescale 1ns/1ps
module mb_parity (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Core side
  link_core_if.par lc
);

  logic [11:0] crc_run;
  logic [11:0] next_crc_run;
  logic [25:0] fec_run;
  logic [25:0] next_fec_run;
  logic [25:0] held;
  logic [25:0] next_held;

  function automatic logic [11:0] crc_step(input logic [11:0] c0, input logic [63:0] d);
    logic [11:0] c;
    logic fb;
    c = c0;
    for (int i = 0; i < jal_pkg::BLK_DATA_W; i++) begin
      fb = d[i] ^ c[jal_pkg::CRC_W-1];
      c = {c[10:0], 1'b0} ^ (fb ? jal_pkg::CRC_POLY : '0);
    end
    return c;
  endfunction

  function automatic logic [25:0] fec_step(input logic [25:0] c0, input logic [63:0] d);
    logic [25:0] c;
    logic fb;
    c = c0;
    for (int i = 0; i < jal_pkg::BLK_DATA_W; i++) begin
      fb = d[i] ^ c[jal_pkg::FEC_W-1];
      c = {c[24:0], 1'b0} ^ (fb ? jal_pkg::FEC_POLY : '0);
    end
    return c;
  endfunction

  always_comb begin
    logic [11:0] c_new;
    logic [25:0] f_new;
    // Registers start from zero at each multiblock
    c_new = crc_step(lc.par_first ? '0 : crc_run, lc.blk_scr); // R23
    f_new = fec_step(lc.par_first ? '0 : fec_run, lc.blk_scr); // R24
    next_crc_run = crc_run;
    next_fec_run = fec_run;
    next_held = held;
    if (lc.par_step) begin
      next_crc_run = c_new;
      next_fec_run = f_new;
      if (lc.par_last) begin
        next_held = lc.par_fec ? f_new : {14'h0000, c_new};
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crc_run <= '0;
      fec_run <= '0;
      held <= '0;
    end else begin
      crc_run <= next_crc_run;
      fec_run <= next_fec_run;
      held <= next_held;
    end
  end

  assign lc.par_word = held;

endmodule // mb_parity

// file: core/jesd_link_alignment_framing.sv
// Transmit link layer: 8b/10b alignment character insertion and 64b/66b block framing.
// Assumes inputs synchronous to clk_i, one octet or one block per valid cycle, SYSREF sampled.
//
// Notes on behaviour
// [R1] Unscrambled repeat of last octet becomes K28.7
// [R2] Repeat at multiframe end becomes K28.3 instead
// [R3] Receiver checks alignment characters land correctly
// [R4] Receiver restores previous final octet, unscrambled
// [R5] Scrambled frame-final 0xFC sent as K28.7
// [R6] Scrambled multiframe-final 0x7C sent as K28.3
// [R7] Receiver maps K28.7/K28.3 back to octets
// [R8] Receiver flags errors, asserts SYNC, SYSREF reissued
// [R9] Eight octets, scrambled, then two-bit header
// [R10] Header bits 0-1, octets ascending after
// [R11] Thirty-two blocks form one multiblock
// [R12] Extended multiblock length fixed at one
// [R13] SYSREF resets extended multiblock clock phase
// [R14] Periodic SYSREF divides multiblock clock rate
// [R15] Sync header always 01 or 10
// [R16] Receiver finds blocks from header transitions
// [R17] Header 01 sends one, 10 sends zero
// [R18] Stream ends with 00001 end marker
// [R19] Stream bit 22 flags extended multiblock end
// [R20] Stream carries CRC-12 or FEC only
// [R21] Receiver confirms FEC marker over multiblocks
// [R22] 64b/66b always scrambled, 8b/10b optional
// [R23] CRC-12 over multiblock, sent next multiblock
// [R24] FEC-26 over multiblock, sent next multiblock
// [R25] Local multiframe phase picks last frame
// [R26] Encoding mode selects which path runs
`timescale 1ns/1ps
module jesd_link_alignment_framing (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Configuration
  input wire logic link_mode_i,
  input wire logic scramble_enable_i,
  input wire logic sh_fec_i,
  input wire logic [7:0] frame_len_m1_i,
  input wire logic [7:0] mf_len_m1_i,
  // Timing reference
  input wire logic sysref_i,
  // 8b/10b octet stream in
  input wire logic oct_valid_i,
  input wire logic [7:0] oct_i,
  // 64b/66b block stream in
  input wire logic blk_valid_i,
  input wire logic [63:0] blk_i,
  // 8b/10b characters out
  output logic oct_valid_o,
  output logic [7:0] oct_o,
  output logic oct_ctrl_o,
  output logic mf_end_o,
  // 64b/66b blocks out
  output logic blk_valid_o,
  output logic [65:0] blk_o,
  output logic mb_end_o
);

  link_core_if lc ();

  line_scrambler u_scr (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .lc(lc.scramble_enable)
  );

  mb_parity u_par (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .lc(lc.par)
  );

  // Builds the 32-bit sync header stream for one multiblock
  function automatic logic [31:0] sh_stream(input logic [25:0] par, input logic fec);
    logic [31:0] s;
    int k;
    if (fec) begin
      s = jal_pkg::FEC_PILOT_MASK; // R18
      k = jal_pkg::FEC_W - 1;
      for (int p = 0; p < jal_pkg::FEC_FIELD_END; p++) begin
        if (p != jal_pkg::EOEMB_BIT) begin
          s[p] = par[k];
          k--;
        end
      end
    end else begin
      s = jal_pkg::CRC_PILOT_MASK; // R18
      k = jal_pkg::CRC_W - 1;
      for (int p = 0; p < jal_pkg::CRC_FIELD_END; p++) begin
        if ((p % jal_pkg::CRC_PILOT_STRIDE) != (jal_pkg::CRC_PILOT_STRIDE - 1)) begin
          s[p] = par[k];
          k--;
        end
      end
    end
    // Every multiblock closes an extended multiblock since its length is one
    s[jal_pkg::EOEMB_BIT] = (jal_pkg::EMB_LEN == 1); // R12 R19
    return s;
  endfunction

  // Wrapping counter step shared by the octet and frame phase counters
  function automatic logic [7:0] wrap_inc(input logic [7:0] v, input logic [7:0] last);
    return (v == last) ? jal_pkg::CNT_ZERO : v + jal_pkg::CNT_ONE;
  endfunction

  // SYSREF edge detection
  logic sysref_q;
  logic next_sysref_q;
  logic sysref_rise;

  always_comb begin
    next_sysref_q = sysref_i;
    sysref_rise = sysref_i && !sysref_q;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sysref_q <= 1'b0;
    end else begin
      sysref_q <= next_sysref_q;
    end
  end

  // 8b/10b path: local multiframe phase and alignment character substitution
  logic [7:0] oct_idx;
  logic [7:0] next_oct_idx;
  logic [7:0] frm_idx;
  logic [7:0] next_frm_idx;
  logic [7:0] prev_last;
  logic [7:0] next_prev_last;
  logic prev_ok;
  logic next_prev_ok;
  logic next_oct_valid;
  logic [7:0] next_oct;
  logic next_oct_ctrl;
  logic next_mf_end;

  always_comb begin
    logic [7:0] eff_oct;
    logic [7:0] eff_frm;
    logic frame_end;
    logic mf_end;
    logic [7:0] d;
    // SYSREF makes the current item the first of a multiframe
    eff_oct = sysref_rise ? jal_pkg::CNT_ZERO : oct_idx;
    eff_frm = sysref_rise ? jal_pkg::CNT_ZERO : frm_idx;
    frame_end = (eff_oct == frame_len_m1_i);
    mf_end = frame_end && (eff_frm == mf_len_m1_i); // R25
    lc.oct_step = (link_mode_i == jal_pkg::MODE_8B10B) && oct_valid_i; // R26
    lc.oct_scr_en = scramble_enable_i; // R22
    lc.oct_raw = oct_i;
    d = lc.oct_scr;
    next_oct_idx = eff_oct;
    next_frm_idx = eff_frm;
    next_prev_last = prev_last;
    next_prev_ok = prev_ok && !sysref_rise;
    next_oct_valid = lc.oct_step;
    next_oct = d;
    next_oct_ctrl = 1'b0;
    next_mf_end = 1'b0;
    if (lc.oct_step) begin
      next_oct_idx = wrap_inc(eff_oct, frame_len_m1_i);
      if (frame_end) begin
        next_frm_idx = wrap_inc(eff_frm, mf_len_m1_i);
        next_mf_end = mf_end;
        if (scramble_enable_i) begin
          if (mf_end && d == jal_pkg::MF_MARK_OCTET) begin
            next_oct = jal_pkg::K28_3_CODE; // R6
            next_oct_ctrl = 1'b1; // R6
          end else if (d == jal_pkg::FRAME_MARK_OCTET) begin
            next_oct = jal_pkg::K28_7_CODE; // R5
            next_oct_ctrl = 1'b1; // R5
          end
        end else if (prev_ok && d == prev_last) begin
          next_oct = mf_end ? jal_pkg::K28_3_CODE : jal_pkg::K28_7_CODE; // R1 R2
          next_oct_ctrl = 1'b1; // R1
        end
        // The repeat check compares data octets, never the substituted character
        next_prev_last = d;
        next_prev_ok = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oct_idx <= jal_pkg::CNT_ZERO;
      frm_idx <= jal_pkg::CNT_ZERO;
      prev_last <= jal_pkg::OCT_RESET;
      prev_ok <= 1'b0;
      oct_valid_o <= 1'b0;
      oct_o <= jal_pkg::OCT_RESET;
      oct_ctrl_o <= 1'b0;
      mf_end_o <= 1'b0;
    end else begin
      oct_idx <= next_oct_idx;
      frm_idx <= next_frm_idx;
      prev_last <= next_prev_last;
      prev_ok <= next_prev_ok;
      oct_valid_o <= next_oct_valid;
      oct_o <= next_oct;
      oct_ctrl_o <= next_oct_ctrl;
      mf_end_o <= next_mf_end;
    end
  end

  // 64b/66b path: block index within the multiblock and header insertion
  logic [4:0] blk_idx;
  logic [4:0] next_blk_idx;
  logic next_blk_valid;
  logic [65:0] next_blk;
  logic next_mb_end;

  always_comb begin
    logic [4:0] eff_blk;
    logic [31:0] shs;
    logic sh_bit;
    // Extended multiblock clock restarts on SYSREF
    eff_blk = sysref_rise ? jal_pkg::BLK_ZERO : blk_idx; // R13
    lc.blk_step = (link_mode_i == jal_pkg::MODE_64B66B) && blk_valid_i; // R26 R22
    lc.blk_raw = blk_i; // R9
    lc.par_step = lc.blk_step;
    lc.par_first = (eff_blk == jal_pkg::BLK_ZERO);
    lc.par_last = (eff_blk == jal_pkg::BLK_IDX_LAST); // R11
    lc.par_fec = sh_fec_i; // R20
    // Parity of the previous multiblock rides in this one
    shs = sh_stream(lc.par_word, sh_fec_i); // R23 R24
    sh_bit = shs[eff_blk]; // R17
    next_blk_idx = eff_blk;
    next_blk_valid = lc.blk_step;
    next_blk = blk_o;
    next_mb_end = 1'b0;
    if (lc.blk_step) begin
      next_blk_idx = eff_blk + jal_pkg::BLK_ONE; // R11
      // Bit 0 is the first header bit; the pair is always complementary
      next_blk = {lc.blk_scr, sh_bit, ~sh_bit}; // R10 R15 R17
      next_mb_end = lc.par_last;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blk_idx <= jal_pkg::BLK_ZERO;
      blk_valid_o <= 1'b0;
      blk_o <= '0;
      mb_end_o <= 1'b0;
    end else begin
      blk_idx <= next_blk_idx;
      blk_valid_o <= next_blk_valid;
      blk_o <= next_blk;
      mb_end_o <= next_mb_end;
    end
  end

endmodule // jesd_link_alignment_framing

// file: tb/jesd_link_alignment_framing_props.sv
// Concurrent checks on the ports of the link alignment and framing core.
// Assumes one clock domain with the asynchronous active-low reset.
`timescale 1ns/1ps
module jesd_link_alignment_framing_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Configuration and timing
  input wire logic link_mode_i,
  input wire logic sh_fec_i,
  input wire logic sysref_i,
  // Inputs
  input wire logic oct_valid_i,
  input wire logic blk_valid_i,
  // Outputs
  input wire logic oct_valid_o,
  input wire logic [7:0] oct_o,
  input wire logic oct_ctrl_o,
  input wire logic mf_end_o,
  input wire logic blk_valid_o,
  input wire logic [65:0] blk_o,
  input wire logic mb_end_o
);
  logic sr_q;
  logic sr_hit;
  logic ok;
  logic [4:0] cnt;
  logic [4:0] idx;

  // Block index is only trusted once SYSREF has landed on a block, or straight from reset
  assign idx = sr_hit ? 5'h00 : cnt;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sr_q <= 1'b0;
      sr_hit <= 1'b0;
      ok <= 1'b1;
      cnt <= 5'h00;
    end else begin
      sr_q <= sysref_i;
      sr_hit <= sysref_i && !sr_q && blk_valid_i && link_mode_i;
      if (blk_valid_o) cnt <= idx + 5'h01;
      if (sr_hit) ok <= 1'b1;
      else if (sysref_i && !sr_q && !(blk_valid_i && link_mode_i)) ok <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence hdr_one;
    blk_o[1:0] == 2'b10;
  endsequence
  sequence hdr_zero;
    blk_o[1:0] == 2'b01;
  endsequence

  chk_oct_answer: assert property (oct_valid_i && !link_mode_i |=> oct_valid_o)
    else $error("octet not answered one cycle later");
  chk_oct_refused: assert property (link_mode_i |=> !oct_valid_o && !oct_ctrl_o)
    else $error("octet passed in block mode");
  chk_blk_answer: assert property (blk_valid_i && link_mode_i |=> blk_valid_o)
    else $error("block not answered one cycle later");
  chk_blk_refused: assert property (!link_mode_i |=> !blk_valid_o && !mb_end_o)
    else $error("block passed in octet mode");
  chk_sh_complement: assert property (blk_valid_o |-> blk_o[0] != blk_o[1])
    else $error("sync header bits equal");
  chk_blk_hold: assert property (!blk_valid_o |-> $stable(blk_o))
    else $error("block output moved between blocks");
  chk_mb_boundary: assert property (blk_valid_o && ok |-> mb_end_o == (idx == 5'h1F))
    else $error("multiblock end misplaced");
  chk_eomb_zeros: assert property (blk_valid_o && ok && idx inside {[27:30]} |-> hdr_zero)
    else $error("end marker zero bit wrong");
  chk_eomb_one: assert property (blk_valid_o && mb_end_o |-> hdr_one)
    else $error("end marker final bit wrong");
  chk_eoemb_flag: assert property (blk_valid_o && ok && idx == 5'h16 |-> hdr_one)
    else $error("extended multiblock flag clear");
  chk_crc_ones: assert property (blk_valid_o && ok && !sh_fec_i
      && idx inside {3, 7, 11, 15, 19, 21, 23} |-> hdr_one)
    else $error("fixed one missing in stream");
  chk_ctrl_frame: assert property (oct_valid_o && oct_ctrl_o && !mf_end_o |-> oct_o == 8'hFC)
    else $error("wrong control code at frame end");
  chk_ctrl_valid: assert property (oct_ctrl_o || mf_end_o |-> oct_valid_o)
    else $error("octet flag without octet");
endmodule // jesd_link_alignment_framing_props

bind jesd_link_alignment_framing jesd_link_alignment_framing_props props_i (
  .clk_i, .rst_n_i, .link_mode_i, .sh_fec_i, .sysref_i, .oct_valid_i, .blk_valid_i,
  .oct_valid_o, .oct_o, .oct_ctrl_o, .mf_end_o, .blk_valid_o, .blk_o, .mb_end_o
);

// file: tb/jesd_rx_model.sv
// Receiver model: restores alignment characters, counts misplaced ones and bad headers.
// Assumes the lane as characters and 66-bit blocks on the core clock, SYSREF shared.
`timescale 1ns/1ps
module jesd_rx_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Link settings and timing
  input wire logic scramble_enable_i,
  input wire logic [7:0] frame_len_m1_i,
  input wire logic [7:0] mf_len_m1_i,
  input wire logic sysref_i,
  // Lane
  input wire logic oct_valid_i,
  input wire logic [7:0] oct_i,
  input wire logic oct_ctrl_i,
  input wire logic blk_valid_i,
  input wire logic [65:0] blk_i,
  // Results
  output logic [7:0] rx_oct_o,
  output logic [15:0] misplaced_o,
  output logic [15:0] bad_hdr_o
);
  logic [7:0] oc;
  logic [7:0] fc;
  logic [7:0] last;
  logic sr_q;
  logic pend;
  logic at_end;
  logic at_mf;

  // A SYSREF rise makes the next received character the first of a multiframe
  assign at_end = (pend ? 8'h00 : oc) == frame_len_m1_i;
  assign at_mf = at_end && (pend ? 8'h00 : fc) == mf_len_m1_i;
  assign rx_oct_o = (oct_ctrl_i && !scramble_enable_i) ? last : oct_i;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {oc, fc, last, sr_q, pend} <= '0;
      misplaced_o <= 16'h0000;
      bad_hdr_o <= 16'h0000;
    end else begin
      sr_q <= sysref_i;
      if (oct_valid_i) begin
        pend <= 1'b0;
        oc <= at_end ? 8'h00 : (pend ? 8'h00 : oc) + 8'h01;
        fc <= at_mf ? 8'h00 : (pend ? 8'h00 : fc) + {7'h00, at_end};
        if (at_end) last <= rx_oct_o;
        if (oct_ctrl_i && !(at_end && (at_mf || oct_i == 8'hFC))) begin
          misplaced_o <= misplaced_o + 16'h0001;
        end
      end
      if (sysref_i && !sr_q) pend <= 1'b1;
      if (blk_valid_i && blk_i[0] == blk_i[1]) bad_hdr_o <= bad_hdr_o + 16'h0001;
    end
  end
endmodule // jesd_rx_model

// file: tb/tb_jesd_link_alignment_framing.sv
// Self-checking bench for the link alignment and framing core.
// Assumes the receiver model beside the core and the checker bound to it.
`timescale 1ns/1ps
module tb_jesd_link_alignment_framing;
  logic clk_i, rst_n_i, link_mode_i, scramble_enable_i, sh_fec_i, sysref_i;
  logic oct_valid_i, blk_valid_i, oct_valid_o, oct_ctrl_o, mf_end_o, blk_valid_o, mb_end_o;
  logic [7:0] frame_len_m1_i, mf_len_m1_i, oct_i, oct_o, rx_oct;
  logic [63:0] blk_i;
  logic [65:0] blk_o;
  logic [15:0] misplaced, bad_hdr;
  logic [14:0] s8;
  logic [57:0] s64;
  int err_total = 0;
  int checks = 0;
  int cycles = 0;

  jesd_link_alignment_framing uut (
    .clk_i, .rst_n_i, .link_mode_i, .scramble_enable_i, .sh_fec_i, .frame_len_m1_i,
    .mf_len_m1_i, .sysref_i, .oct_valid_i, .oct_i, .blk_valid_i, .blk_i, .oct_valid_o,
    .oct_o, .oct_ctrl_o, .mf_end_o, .blk_valid_o, .blk_o, .mb_end_o
  );
  jesd_rx_model rx (
    .clk_i, .rst_n_i, .scramble_enable_i, .frame_len_m1_i, .mf_len_m1_i, .sysref_i,
    .oct_valid_i(oct_valid_o), .oct_i(oct_o), .oct_ctrl_i(oct_ctrl_o),
    .blk_valid_i(blk_valid_o), .blk_i(blk_o), .rx_oct_o(rx_oct),
    .misplaced_o(misplaced), .bad_hdr_o(bad_hdr)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 1000) begin
      err_total = err_total + 1;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [65:0] exp, input logic [65:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic do_reset(input logic mode, input logic scramble_enable);
    @(posedge clk_i);
    #1;
    rst_n_i = 1'b0;
    link_mode_i = mode;
    scramble_enable_i = scramble_enable;
    sh_fec_i = 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    s8 = 15'h7FFF;
    s64 = 58'h3FF_FFFF_FFFF_FFFF;
  endtask

  // Works backwards from the wanted scrambled octet, so targets such as 0xFC can be forced
  function automatic logic [7:0] unscr8(input logic [7:0] t);
    logic [7:0] d;
    for (int b = 7; b >= 0; b--) begin
      d[b] = t[b] ^ s8[13] ^ s8[14];
      s8 = {s8[13:0], t[b]};
    end
    return d;
  endfunction

  function automatic logic [63:0] scr64(input logic [63:0] d);
    logic [63:0] s;
    for (int b = 0; b < 64; b++) begin
      s[b] = d[b] ^ s64[38] ^ s64[57];
      s64 = {s64[56:0], s[b]};
    end
    return s;
  endfunction

  // Eight octets back to back, two-octet frames, two frames per multiframe
  task automatic run_oct(input logic scramble_enable, input logic [63:0] t, input logic [63:0] eo,
                         input logic [7:0] ec, input logic [7:0] em);
    do_reset(1'b0, scramble_enable);
    for (int i = 0; i < 8; i++) begin
      oct_i = scramble_enable ? unscr8(t[8*i+:8]) : t[8*i+:8];
      oct_valid_i = 1'b1;
      sysref_i = (i == 0);
      @(posedge clk_i);
      #1;
      chk("octet", {1'b1, ec[i], em[i], eo[8*i+:8]}, {oct_valid_o, oct_ctrl_o, mf_end_o, oct_o});
      chk("restored", t[8*i+:8], rx_oct);
    end
    oct_valid_i = 1'b0;
    sysref_i = 1'b0;
    @(posedge clk_i);
    #1;
    chk("misplaced", 16'h0000, misplaced);
  endtask

  task automatic t_unscr;
    run_oct(1'b0, 64'h2355_2244_2233_2211, 64'h2355_FC44_7C33_2211, 8'h28, 8'h88);
  endtask

  task automatic t_scr;
    run_oct(1'b1, 64'hFC01_7C00_7C7C_FCFC, 64'hFC01_7C00_7C7C_FCFC, 8'h8A, 8'h88);
  endtask

  // Four multiblocks: two with CRC content, two with FEC content; SYSREF once per multiblock
  task automatic t_blocks;
    logic [63:0] sd;
    logic [31:0] sw;
    logic [31:0] ew;
    logic [11:0] crc;
    logic [25:0] fec;
    logic [25:0] held;
    logic fb;
    do_reset(1'b1, 1'b0);
    oct_valid_i = 1'b1;
    held = 26'h000_0000;
    for (int i = 0; i < 128; i++) begin
      blk_i = {32'(i) ^ 32'hA5A5_0F0F, ~32'(i)};
      blk_valid_i = 1'b1;
      sysref_i = (i % 32 == 0);
      sh_fec_i = (i >= 64);
      sd = scr64(blk_i);
      if (i % 32 == 0) begin
        crc = 12'h000;
        fec = 26'h000_0000;
      end
      for (int b = 0; b < 64; b++) begin
        fb = sd[b] ^ crc[11];
        crc = {crc[10:0], 1'b0} ^ (fb ? 12'h987 : 12'h000);
        fb = sd[b] ^ fec[25];
        fec = {fec[24:0], 1'b0} ^ (fb ? 26'h022_0211 : 26'h000_0000);
      end
      @(posedge clk_i);
      #1;
      chk("block", {1'b1, i % 32 == 31, sd}, {blk_valid_o, mb_end_o, blk_o[65:2]});
      sw[i % 32] = ~blk_o[0];
      if (i % 32 == 31) begin
        if (!sh_fec_i) begin
          ew = 32'h80E8_8888;
          for (int k = 0; k < 12; k++) ew[k + k / 3] = held[11 - k];
        end else begin
          ew = 32'h8040_0000;
          for (int k = 0; k < 26; k++) ew[k + int'(k > 21)] = held[25 - k];
        end
        chk("stream", ew, sw);
        if (i >= 64) chk("fec pilot", 32'h8040_0000, sw & 32'hF840_0000);
        // The word closed here rides in the next multiblock, in the layout then selected
        held = sh_fec_i ? fec : {14'h0000, crc};
      end
    end
    blk_valid_i = 1'b0;
    oct_valid_i = 1'b0;
    sysref_i = 1'b0;
    @(posedge clk_i);
    #1;
    chk("bad headers", 16'h0000, bad_hdr);
  endtask

  initial begin
    rst_n_i = 1'b0;
    link_mode_i = 1'b0;
    scramble_enable_i = 1'b0;
    sh_fec_i = 1'b0;
    frame_len_m1_i = 8'h01;
    mf_len_m1_i = 8'h01;
    sysref_i = 1'b0;
    oct_valid_i = 1'b0;
    oct_i = 8'h00;
    blk_valid_i = 1'b0;
    blk_i = 64'h0000_0000_0000_0000;
    t_unscr();
    t_scr();
    t_blocks();
    close_out();
  end
endmodule // tb_jesd_link_alignment_framing
